// ### src/mpwm_map.svh
// register offsets, field positions, reset values, generator count and dead-band width of the motor pwm block
// assumes a plain register port with byte addresses and 32-bit data
`ifndef MPWM_MAP_SVH
`define MPWM_MAP_SVH
`define MPWM_NGEN        3
// global registers
`define MPWM_R_ENABLE    8'h00
`define MPWM_R_INVERT    8'h04
`define MPWM_R_FAULTEN   8'h08
`define MPWM_R_ISTAT     8'h0c
`define MPWM_R_IMASK     8'h10
`define MPWM_R_FAULTST   8'h14
// per generator block: base 0x40 + 0x40*n
`define MPWM_G_BASE      8'h40
`define MPWM_G_STRIDE    8'h40
`define MPWM_G_CTL       4'h0
`define MPWM_G_LOAD      4'h1
`define MPWM_G_COUNT     4'h2
`define MPWM_G_CMPA      4'h3
`define MPWM_G_CMPB      4'h4
`define MPWM_G_GENA      4'h5
`define MPWM_G_GENB      4'h6
`define MPWM_G_DBCTL     4'h7
`define MPWM_G_DBRISE    4'h8
`define MPWM_G_DBFALL    4'h9
`define MPWM_G_EVSEL     4'ha
// ctl fields
`define MPWM_CTL_RUN     0
`define MPWM_CTL_UPDOWN  1
`define MPWM_CTL_SYNCUPD 2
// event bit positions: zero, load, cmpa up, cmpa down, cmpb up, cmpb down
`define MPWM_EV_ZERO     0
`define MPWM_EV_LOAD     1
`define MPWM_EV_AUP      2
`define MPWM_EV_ADN      3
`define MPWM_EV_BUP      4
`define MPWM_EV_BDN      5
`define MPWM_DB_W        12
`define MPWM_RST_LOAD    16'hffff
`endif

// ### src/mpwm_pkg.sv
// types shared by the motor pwm block
// used by name only, never imported
package mpwm_pkg;
  typedef enum logic [1:0] {
    MPWM_ACT_NONE = 2'b00,
    MPWM_ACT_INV  = 2'b01,
    MPWM_ACT_LOW  = 2'b10,
    MPWM_ACT_HIGH = 2'b11
  } mpwm_act_t;
  typedef enum logic [0:0] {
    MPWM_DIR_DOWN = 1'b0,
    MPWM_DIR_UP   = 1'b1
  } mpwm_dir_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mpwm_bus_t;
endpackage

// ### src/mpwm_top.sv
// motor pwm block: three generators, dead-band, output control, fault and interrupt logic
// assumes synchronous inputs on ref_clk_in and a one-cycle register port
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_top (
  input  wire logic        ref_clk_in,    // 50 MHz clock
  input  wire logic        rstn_in,       // async reset, active low
  input  wire logic        clk_en_in,     // freezes all state when low
  input  wire logic [7:0]  addr_in,       // byte address
  input  wire logic [31:0] wdata_in,      // write data
  input  wire logic        wr_in,         // write strobe
  input  wire logic        rd_in,         // read strobe
  input  wire logic        fault_in,      // fault, active high
  output logic      [31:0] rdata_out,     // read data, cycle after rd
  output logic      [5:0]  pwm_out,       // pwm pins
  output logic             irq_out,       // level interrupt
  output logic      [2:0]  adc_trig_out   // one-cycle adc trigger per generator
);
  localparam int N = `MPWM_NGEN;
  mpwm_pkg::mpwm_bus_t bus;
  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  logic [5:0]  enable_r, invert_r, faulten_r;
  logic [2:0]  istat_r, imask_r;
  logic        fault_st_r;
  logic [2:0]  ctl_r     [N];
  logic [15:0] load_r    [N], load_act_r [N], cnt_r [N];
  logic [15:0] cmpa_r    [N], cmpa_act_r [N], cmpb_r [N], cmpb_act_r [N];
  logic [11:0] gena_r    [N], genb_r [N];
  logic        dben_r    [N];
  logic [`MPWM_DB_W-1:0] dbrise_r [N], dbfall_r [N], dbcnt_r [N];
  logic [11:0] evsel_r   [N];
  logic        dir_r     [N];
  logic [1:0]  wave_r    [N];
  logic [1:0]  db_r      [N];
  logic        dbprev_r  [N];
  logic [5:0]  ev        [N];
  logic [2:0]  irq_ev;

  // apply one programmed action to a waveform level
  function automatic logic act(input logic cur, input logic [1:0] a);
    case (mpwm_pkg::mpwm_act_t'(a))
      mpwm_pkg::MPWM_ACT_INV:  act = ~cur;
      mpwm_pkg::MPWM_ACT_LOW:  act = 1'b0;
      mpwm_pkg::MPWM_ACT_HIGH: act = 1'b1;
      default:                 act = cur;
    endcase
  endfunction

  // generator-register hit: true when the address is register r within block g
  function automatic logic ghit(input logic [7:0] a, input int g, input logic [3:0] r);
    ghit = (a == 8'((`MPWM_G_BASE + g * `MPWM_G_STRIDE) + {r, 2'b00}));
  endfunction

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_blk
      logic zero_ev, load_ev, a_m, b_m, upd;
      assign zero_ev = ctl_r[g][`MPWM_CTL_RUN] && (cnt_r[g] == 16'h0000);
      assign load_ev = ctl_r[g][`MPWM_CTL_RUN] && (cnt_r[g] == load_act_r[g]);
      assign a_m     = ctl_r[g][`MPWM_CTL_RUN] && (cnt_r[g] == cmpa_act_r[g]);
      assign b_m     = ctl_r[g][`MPWM_CTL_RUN] && (cnt_r[g] == cmpb_act_r[g]);
      assign ev[g]   = {b_m & ~dir_r[g], b_m & dir_r[g], a_m & ~dir_r[g], a_m & dir_r[g], load_ev, zero_ev};
      assign upd     = ~ctl_r[g][`MPWM_CTL_SYNCUPD] | zero_ev | ~ctl_r[g][`MPWM_CTL_RUN];

      // counter: down-only reloads at zero, up/down turns at zero and load
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          cnt_r[g] <= 16'h0000;
          dir_r[g] <= mpwm_pkg::MPWM_DIR_DOWN;
        end else if (clk_en_in && ctl_r[g][`MPWM_CTL_RUN]) begin
          if (ctl_r[g][`MPWM_CTL_UPDOWN]) begin
            if (zero_ev) begin
              dir_r[g] <= mpwm_pkg::MPWM_DIR_UP;
              cnt_r[g] <= (load_act_r[g] == 16'h0000) ? 16'h0000 : 16'h0001;
            end else if (load_ev || cnt_r[g] > load_act_r[g]) begin
              dir_r[g] <= mpwm_pkg::MPWM_DIR_DOWN;
              cnt_r[g] <= cnt_r[g] - 16'h0001;
            end else begin
              cnt_r[g] <= dir_r[g] ? cnt_r[g] + 16'h0001 : cnt_r[g] - 16'h0001;
            end
          end else begin
            dir_r[g] <= mpwm_pkg::MPWM_DIR_DOWN;
            cnt_r[g] <= zero_ev ? load_act_r[g] : cnt_r[g] - 16'h0001;
          end
        end
      end

      // shadow to active copies, immediately or at counter zero
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          load_act_r[g] <= `MPWM_RST_LOAD;
          cmpa_act_r[g] <= 16'h0000;
          cmpb_act_r[g] <= 16'h0000;
        end else if (clk_en_in && upd) begin
          load_act_r[g] <= load_r[g];
          cmpa_act_r[g] <= cmpa_r[g];
          cmpb_act_r[g] <= cmpb_r[g];
        end
      end

      // waveform builder: later events in the list take priority
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          wave_r[g] <= 2'b00;
        end else if (clk_en_in) begin
          logic wa, wb;
          wa = wave_r[g][0];
          wb = wave_r[g][1];
          for (int e = 0; e < 6; e++) begin
            if (ev[g][e]) begin
              wa = act(wa, gena_r[g][2*e +: 2]);
              wb = act(wb, genb_r[g][2*e +: 2]);
            end
          end
          wave_r[g] <= {wb, wa};
        end
      end

      // dead-band: output 0 follows a rising after rise delay, output 1 its complement after fall delay
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          db_r[g]     <= 2'b00;
          dbprev_r[g] <= 1'b0;
          dbcnt_r[g]  <= '0;
        end else if (clk_en_in) begin
          dbprev_r[g] <= wave_r[g][0];
          if (!dben_r[g]) begin
            db_r[g]    <= wave_r[g];
            dbcnt_r[g] <= '0;
          end else if (wave_r[g][0] != dbprev_r[g]) begin
            db_r[g]    <= 2'b00;
            dbcnt_r[g] <= wave_r[g][0] ? dbrise_r[g] : dbfall_r[g];
          end else if (dbcnt_r[g] != '0) begin
            dbcnt_r[g] <= dbcnt_r[g] - 1'b1;
          end else begin
            db_r[g] <= {~wave_r[g][0], wave_r[g][0]};
          end
        end
      end
    end
  endgenerate

  // selectors: evsel low six bits pick interrupt events, high six pick adc triggers
  always_comb begin
    for (int i = 0; i < N; i++) begin
      irq_ev[i] = |(ev[i] & evsel_r[i][5:0]);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      adc_trig_out <= 3'h0;
    end else if (clk_en_in) begin
      for (int i = 0; i < N; i++) begin
        adc_trig_out[i] <= |(ev[i] & evsel_r[i][11:6]);
      end
    end
  end

  // sticky interrupt status: set wins over write-one-to-clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      istat_r    <= 3'h0;
      fault_st_r <= 1'b0;
    end else if (clk_en_in) begin
      logic [2:0] clr;
      clr = (bus.wr && bus.addr == `MPWM_R_ISTAT) ? bus.wdata[2:0] : 3'h0;
      istat_r <= (istat_r & ~clr) | irq_ev;
      if (fault_in) begin
        fault_st_r <= 1'b1;
      end else if (bus.wr && bus.addr == `MPWM_R_FAULTST && bus.wdata[0]) begin
        fault_st_r <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enable_r  <= 6'h00;
      invert_r  <= 6'h00;
      faulten_r <= 6'h00;
      imask_r   <= 3'h0;
      for (int i = 0; i < N; i++) begin
        ctl_r[i]    <= 3'h0;
        load_r[i]   <= `MPWM_RST_LOAD;
        cmpa_r[i]   <= 16'h0000;
        cmpb_r[i]   <= 16'h0000;
        gena_r[i]   <= 12'h000;
        genb_r[i]   <= 12'h000;
        dben_r[i]   <= 1'b0;
        dbrise_r[i] <= '0;
        dbfall_r[i] <= '0;
        evsel_r[i]  <= 12'h000;
      end
    end else if (clk_en_in && bus.wr) begin
      case (bus.addr)
        `MPWM_R_ENABLE:  enable_r  <= bus.wdata[5:0];
        `MPWM_R_INVERT:  invert_r  <= bus.wdata[5:0];
        `MPWM_R_FAULTEN: faulten_r <= bus.wdata[5:0];
        `MPWM_R_IMASK:   imask_r   <= bus.wdata[2:0];
        default: begin
        end
      endcase
      for (int i = 0; i < N; i++) begin
        if (ghit(bus.addr, i, `MPWM_G_CTL))    ctl_r[i]    <= bus.wdata[2:0];
        if (ghit(bus.addr, i, `MPWM_G_LOAD))   load_r[i]   <= bus.wdata[15:0];
        if (ghit(bus.addr, i, `MPWM_G_CMPA))   cmpa_r[i]   <= bus.wdata[15:0];
        if (ghit(bus.addr, i, `MPWM_G_CMPB))   cmpb_r[i]   <= bus.wdata[15:0];
        if (ghit(bus.addr, i, `MPWM_G_GENA))   gena_r[i]   <= bus.wdata[11:0];
        if (ghit(bus.addr, i, `MPWM_G_GENB))   genb_r[i]   <= bus.wdata[11:0];
        if (ghit(bus.addr, i, `MPWM_G_DBCTL))  dben_r[i]   <= bus.wdata[0];
        if (ghit(bus.addr, i, `MPWM_G_DBRISE)) dbrise_r[i] <= bus.wdata[`MPWM_DB_W-1:0];
        if (ghit(bus.addr, i, `MPWM_G_DBFALL)) dbfall_r[i] <= bus.wdata[`MPWM_DB_W-1:0];
        if (ghit(bus.addr, i, `MPWM_G_EVSEL))  evsel_r[i]  <= bus.wdata[11:0];
      end
    end
  end

  // register reads, unmapped reads return zero
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 32'h0;
    end else if (clk_en_in) begin
      logic [31:0] d;
      d = 32'h0;
      case (bus.addr)
        `MPWM_R_ENABLE:  d = {26'h0, enable_r};
        `MPWM_R_INVERT:  d = {26'h0, invert_r};
        `MPWM_R_FAULTEN: d = {26'h0, faulten_r};
        `MPWM_R_ISTAT:   d = {29'h0, istat_r};
        `MPWM_R_IMASK:   d = {29'h0, imask_r};
        `MPWM_R_FAULTST: d = {30'h0, fault_in, fault_st_r};
        default: begin
        end
      endcase
      for (int i = 0; i < N; i++) begin
        if (ghit(bus.addr, i, `MPWM_G_CTL))    d = {29'h0, ctl_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_LOAD))   d = {16'h0, load_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_COUNT))  d = {16'h0, cnt_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_CMPA))   d = {16'h0, cmpa_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_CMPB))   d = {16'h0, cmpb_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_GENA))   d = {20'h0, gena_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_GENB))   d = {20'h0, genb_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_DBCTL))  d = {31'h0, dben_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_DBRISE)) d = {20'h0, dbrise_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_DBFALL)) d = {20'h0, dbfall_r[i]};
        if (ghit(bus.addr, i, `MPWM_G_EVSEL))  d = {20'h0, evsel_r[i]};
      end
      rdata_out <= bus.rd ? d : 32'h0;
    end
  end

  // output control: polarity, enable, fault shutdown; fault acts on the raw input level
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pwm_out <= 6'h00;
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      logic [5:0] w;
      for (int i = 0; i < N; i++) begin
        w[2*i +: 2] = db_r[i];
      end
      w = w ^ invert_r;
      w = w & enable_r;
      if (fault_in) begin
        w = w & ~faulten_r;
      end
      pwm_out <= w;
      irq_out <= |((istat_r | irq_ev) & imask_r);
    end
  end
endmodule

// ### verif/mpwm_gate_model.sv
// gate driver model at the pins: follows the gate commands, times gate 0 rise to rise
// assumes registered pins from the pwm block on the same clock
`timescale 1ns/1ps
module mpwm_gate_model (
  input  wire logic        ref_clk_in,  // clock
  input  wire logic [5:0]  pwm_in,      // gate commands
  output logic      [15:0] period_out   // cycles between rises of gate 0
);
  logic [15:0] cnt_r;
  logic        last_r;
  always_ff @(posedge ref_clk_in) begin
    last_r <= pwm_in[0];
    cnt_r <= (pwm_in[0] && !last_r) ? 16'h1 : cnt_r + 16'h1;
    if (pwm_in[0] && !last_r) begin
      period_out <= cnt_r;
    end
  end
endmodule

// ### verif/mpwm_assertions.sv
// checker for the motor pwm block, sees top ports only
// bound to mpwm_top from the testbench top file
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_assertions (
  input wire logic        ref_clk_in,   // clock
  input wire logic        rstn_in,      // reset, active low
  input wire logic        clk_en_in,    // clock enable
  input wire logic [7:0]  addr_in,      // address
  input wire logic [31:0] wdata_in,     // write data
  input wire logic        wr_in,        // write strobe
  input wire logic        rd_in,        // read strobe
  input wire logic        fault_in,     // fault
  input wire logic [31:0] rdata_out,    // read data
  input wire logic [5:0]  pwm_out,      // pins
  input wire logic        irq_out,      // interrupt
  input wire logic [2:0]  adc_trig_out  // adc triggers
);
  logic [5:0] en_r;
  logic [5:0] fen_r;
  logic [2:0] im_r;
  wire        wr_ok = wr_in && clk_en_in;
  // shadows of enable, fault enable and mask registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_r <= 6'h0;
      fen_r <= 6'h0;
      im_r <= 3'h0;
    end else begin
      if (wr_ok && addr_in == `MPWM_R_ENABLE) en_r <= wdata_in[5:0];
      if (wr_ok && addr_in == `MPWM_R_FAULTEN) fen_r <= wdata_in[5:0];
      if (wr_ok && addr_in == `MPWM_R_IMASK) im_r <= wdata_in[2:0];
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  a_rdata_idle: assert property (clk_en_in && !rd_in |=> rdata_out == 32'h0)
    else $error("read data not zero outside read");
  a_unmapped_read: assert property (clk_en_in && rd_in && addr_in == 8'h3c |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_count_width: assert property (clk_en_in && rd_in && addr_in == 8'h48 |=> rdata_out[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  a_fault_kill: assert property (clk_en_in && fault_in |=> (pwm_out & $past(fen_r)) == 6'h0)
    else $error("fault enabled pin active during fault");
  a_enable_gate: assert property ((pwm_out & ~(en_r | $past(en_r))) == 6'h0)
    else $error("disabled pin driven");
  a_irq_masked: assert property (irq_out |-> (im_r | $past(im_r)) != 3'h0)
    else $error("interrupt with all sources masked");
  a_clk_freeze: assert property (!clk_en_in |=> $stable(pwm_out) && $stable(rdata_out))
    else $error("state moved while clock enable low");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn_in |-> pwm_out == 6'h0 && !irq_out && adc_trig_out == 3'h0)
    else $error("outputs active in reset");
  c_fault: cover property (fault_in && fen_r != 6'h0);
  c_irq: cover property ($rose(irq_out));
  c_adc: cover property (adc_trig_out[0]);
endmodule

// ### verif/tb.sv
// self-checking bench for the motor pwm block
// assumes mpwm_top, its map header, the gate model and the checker
`timescale 1ns/1ps
`include "mpwm_map.svh"
module tb;
  logic        ref_clk_in = 1'b0;
  logic        rstn_in = 1'b1;
  logic        clk_en_in = 1'b1;
  logic [7:0]  addr_in = 8'h0;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        fault_in = 1'b0;
  logic [31:0] rdata_out;
  logic [5:0]  pwm_out;
  logic        irq_out;
  logic [2:0]  adc_trig_out;
  logic [15:0] period;
  logic [31:0] d;
  logic [5:0]  p;
  logic        ov;
  logic        sb;
  int          err_count = 0;
  int          n_tests = 0;
  int          k;
  // rows: enable, invert, expected pins while waves idle low
  logic [17:0] rows [4] = '{18'h3f000, 18'h3ffff, 18'h15fd5, 18'h00fc0};
  always #10 ref_clk_in = ~ref_clk_in;
  mpwm_top i_mpwm_top (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .fault_in(fault_in),
    .rdata_out(rdata_out), .pwm_out(pwm_out), .irq_out(irq_out), .adc_trig_out(adc_trig_out));
  mpwm_gate_model i_mpwm_gate_model (.ref_clk_in(ref_clk_in), .pwm_in(pwm_out), .period_out(period));
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    // a real falling edge at time zero so the async reset clears the flops before the first clock
    rstn_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    cyc(1);
    check("reset pins", {26'h0, pwm_out}, 32'h0);
    for (k = 0; k < 4; k++) begin
      wr(`MPWM_R_ENABLE, {26'h0, rows[k][17:12]});
      wr(`MPWM_R_INVERT, {26'h0, rows[k][11:6]});
      cyc(3);
      check("pins", {26'h0, pwm_out}, {26'h0, rows[k][5:0]});
    end
    rd(8'h3c);
    check("unmapped", d, 32'h0);
    rd(8'h84);
    check("load reset", d, 32'h0000ffff);
    wr(`MPWM_R_FAULTEN, 32'h0f);
    wr(`MPWM_R_ENABLE, 32'h3f);
    fault_in <= 1'b1;
    cyc(2);
    check("fault pins", {26'h0, pwm_out}, 32'h30);
    fault_in <= 1'b0;
    rd(`MPWM_R_FAULTST);
    check("fault sticky", {31'h0, d[0]}, 32'h1);
    wr(`MPWM_R_FAULTST, 32'h1);
    wr(`MPWM_R_INVERT, 32'h0);
    wr(`MPWM_R_ENABLE, 32'h01);
    wr(8'h44, 32'h9);
    wr(8'h4c, 32'h4);
    wr(8'h54, 32'h8c);
    wr(8'h68, 32'h41);
    wr(`MPWM_R_IMASK, 32'h1);
    wr(8'h40, 32'h1);
    cyc(45);
    check("period down", {16'h0, period}, 32'ha);
    check("irq set", {31'h0, irq_out}, 32'h1);
    rd(`MPWM_R_ISTAT);
    check("istat sticky", d, 32'h1);
    rd(8'h48);
    check("count range", {31'h0, d <= 32'h9}, 32'h1);
    k = 0;
    repeat (30) begin
      cyc(1);
      if (adc_trig_out[0] === 1'b1) k++;
    end
    check("adc pulses", k, 32'h3);
    wr(`MPWM_R_IMASK, 32'h0);
    wr(`MPWM_R_ISTAT, 32'h1);
    cyc(25);
    check("irq masked", {31'h0, irq_out}, 32'h0);
    clk_en_in <= 1'b0;
    p = pwm_out;
    cyc(4);
    check("frozen pins", {26'h0, pwm_out}, {26'h0, p});
    clk_en_in <= 1'b1;
    wr(8'h40, 32'h3);
    cyc(60);
    check("period updown", {16'h0, period}, 32'h12);
    wr(8'h60, 32'h3);
    wr(8'h64, 32'h3);
    // output b set high at zero only, while a keeps toggling
    wr(8'h58, 32'h3);
    wr(`MPWM_R_ENABLE, 32'h03);
    cyc(24);
    ov = 1'b0;
    sb = 1'b0;
    repeat (20) begin
      cyc(1);
      ov = ov | (pwm_out[0] === 1'b0);
      sb = sb | (pwm_out[1] !== 1'b1);
    end
    check("independent b", {30'h0, ov, sb}, 32'h2);
    wr(8'h5c, 32'h1);
    wr(`MPWM_R_ENABLE, 32'h03);
    ov = 1'b0;
    sb = 1'b0;
    repeat (40) begin
      cyc(1);
      ov = ov | (pwm_out[1:0] === 2'b11);
      sb = sb | (pwm_out[1] === 1'b1);
    end
    check("dead band", {30'h0, ov, sb}, 32'h1);
    // deferred load: down mode with sync update, new load lands only after the next zero
    wr(8'h40, 32'h5);
    k = 0;
    repeat (40) begin
      if (k == 0) begin
        cyc(1);
        if (adc_trig_out[0] === 1'b1) k = 1;
      end
    end
    if (k == 0) begin
      err_count++;
      tally_and_finish();
    end
    wr(8'h44, 32'h30);
    cyc(10);
    rd(8'h48);
    check("sync load", d, 32'h6);
    // stopped generator raises no events, so a write of one clears the status
    wr(8'h40, 32'h0);
    wr(`MPWM_R_ISTAT, 32'h7);
    rd(`MPWM_R_ISTAT);
    check("istat clear", d, 32'h0);
    // reset in mid-run
    rstn_in <= 1'b0;
    cyc(2);
    check("reset pins mid", {25'h0, irq_out, pwm_out}, 32'h0);
    rstn_in <= 1'b1;
    cyc(1);
    rd(8'h44);
    check("load after reset", d, 32'h0000ffff);
    rd(`MPWM_R_ENABLE);
    check("enable after reset", d, 32'h0);
    tally_and_finish();
  end
endmodule
bind mpwm_top mpwm_assertions i_mpwm_assertions (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
  .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .fault_in(fault_in), .rdata_out(rdata_out), .pwm_out(pwm_out), .irq_out(irq_out),
  .adc_trig_out(adc_trig_out));
